// [ses_pkg.sv]
`default_nettype none
package ses_pkg;
	// lane and field geometry
	localparam int LANE_COUNT = 16;
	localparam int TALLY_W = 16;
	localparam int LEVEL_W = 6;
	localparam int PHASE_W = 7;
	localparam int SLOT_W = 5;
	localparam int IDX_W = 10;

	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_RUN_CONTROL = 10'h1f0;
	localparam logic [IDX_W-1:0] IDX_SETUP = 10'h1f1;
	localparam logic [IDX_W-1:0] IDX_PHASE_OFFSET = 10'h1f2;
	localparam logic [IDX_W-1:0] IDX_LEVEL_OFFSET = 10'h1f3;
	localparam logic [IDX_W-1:0] IDX_BIT_SLOT = 10'h1f4;
	localparam logic [IDX_W-1:0] IDX_TALLY_CLEAR = 10'h1f5;
	localparam logic [IDX_W-1:0] IDX_FINISHED = 10'h1f6;
	localparam logic [IDX_W-1:0] IDX_LEVEL_BASE = 10'h200;
	localparam logic [IDX_W-1:0] IDX_TALLY_BASE = 10'h210;

	// reset values
	localparam logic [7:0] RST_RUN_CONTROL = 8'h00;
	localparam logic [7:0] RST_SETUP = 8'h00;
	localparam logic [7:0] RST_PHASE_OFFSET = 8'h00;
	localparam logic [7:0] RST_LEVEL_OFFSET = 8'h00;
	localparam logic [7:0] RST_BIT_SLOT = 8'h00;
	localparam logic [7:0] RST_TALLY_CLEAR = 8'h00;

	// field positions
	localparam int GO_BIT = 0;
	localparam int CLEAR_BIT = 0;
	localparam int LEN_LSB = 4;
	localparam int MODE_LSB = 0;

	// sample lengths per scan_length_sel code
	localparam logic [TALLY_W-1:0] LEN_SEL0 = 16'h007f;
	localparam logic [TALLY_W-1:0] LEN_SEL1 = 16'h0408;
	localparam logic [TALLY_W-1:0] LEN_SEL2 = 16'h1fff;
	localparam logic [TALLY_W-1:0] LEN_SEL3 = 16'hffff;

	// scan modes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_ALL = 4'h1;
	localparam logic [3:0] MODE_CMP_ZERO = 4'h2;
	localparam logic [3:0] MODE_CMP_ONE = 4'h3;
	localparam logic [3:0] MODE_CNT_ONES = 4'h4;
	localparam logic [3:0] MODE_AVG_ZERO = 4'h8;
	localparam logic [3:0] MODE_LOW_ZERO = 4'h9;
	localparam logic [3:0] MODE_HIGH_ZERO = 4'ha;
	localparam logic [3:0] MODE_AVG_ONE = 4'hc;
	localparam logic [3:0] MODE_HIGH_ONE = 4'hd;
	localparam logic [3:0] MODE_LOW_ONE = 4'he;

	// signed level limits
	localparam logic [LEVEL_W-1:0] LEVEL_MAX = 6'h1f;
	localparam logic [LEVEL_W-1:0] LEVEL_MIN = 6'h20;
	localparam logic [LEVEL_W-1:0] LEVEL_START = 6'h00;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} ses_state_type;
endpackage
`default_nettype wire

// [ses_eye_scan.sv]
`timescale 1ns/1ps
`default_nettype none
module ses_eye_scan
	import ses_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hreadyin,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// receive samplers, one bit per lane
	input wire logic rx_bit_valid,
	input wire logic [SLOT_W-1:0] rx_bit_pos,
	input wire logic [LANE_COUNT-1:0] rx_data_bit,
	input wire logic [LANE_COUNT-1:0] rx_scan_bit,
	// scan sampler steering
	output logic scan_sampler_en,
	output logic [PHASE_W-1:0] scan_phase_out,
	output logic [LANE_COUNT*LEVEL_W-1:0] scan_level_out
);

	// qualifying sample for a mode, given the normal sampler's bit
	function automatic logic mode_takes(input logic [3:0] mode, input logic data_bit);
		logic r;
		r = 1'b0;
		case (mode)
			MODE_CMP_ALL, MODE_CNT_ONES: r = 1'b1;
			MODE_CMP_ZERO, MODE_AVG_ZERO, MODE_LOW_ZERO, MODE_HIGH_ZERO: r = ~data_bit;
			MODE_CMP_ONE, MODE_AVG_ONE, MODE_HIGH_ONE, MODE_LOW_ONE: r = data_bit;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic mode_is_level(input logic [3:0] mode);
		return (mode == MODE_AVG_ZERO) || (mode == MODE_LOW_ZERO) ||
			(mode == MODE_HIGH_ZERO) || (mode == MODE_AVG_ONE) ||
			(mode == MODE_HIGH_ONE) || (mode == MODE_LOW_ONE);
	endfunction

	function automatic logic [IDX_W-1:0] word_index(input logic [31:0] addr);
		return addr[IDX_W+1:2];
	endfunction

	// registers
	logic [7:0] run_control_reg;
	logic [7:0] scan_setup_reg;
	logic [7:0] phase_offset_reg;
	logic [7:0] level_offset_reg;
	logic [7:0] bit_slot_reg;
	logic [7:0] tally_clear_reg;

	// bus pipeline
	logic wr_pend_reg;
	logic [IDX_W-1:0] wr_idx_reg;
	logic bus_req;
	logic rd_req;
	logic accept;
	logic [31:0] rd_value;

	// scan control
	ses_state_type state_reg;
	logic go_prev_reg;
	logic clear_prev_reg;
	logic scan_start;
	logic scan_abort;
	logic tally_wipe;
	logic [3:0] mode;
	logic [TALLY_W-1:0] length_target;
	logic slot_hit;
	logic [LANE_COUNT-1:0] finished_reg;
	logic [LANE_COUNT-1:0] busy_reg;
	logic [LANE_COUNT-1:0][TALLY_W-1:0] tally_reg;
	logic [LANE_COUNT-1:0][TALLY_W-1:0] samples_reg;
	logic [LANE_COUNT-1:0][LEVEL_W-1:0] level_reg;

	assign mode = scan_setup_reg[MODE_LSB +: 4];
	assign hresp = 1'b0;

	// a read that lands on a pending write's data phase waits one cycle so it sees the new value
	assign bus_req = hsel && htrans[1] && hreadyin;
	assign rd_req = hsel && htrans[1] && !hwrite;
	assign hreadyout = !(wr_pend_reg && rd_req);
	assign accept = bus_req && hreadyout;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= '0;
		end else begin
			wr_pend_reg <= accept && hwrite;
			if (accept) begin
				wr_idx_reg <= word_index(haddr);
			end
		end
	end

	// register writes in the data phase; reserved bits store what is written
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_control_reg <= RST_RUN_CONTROL;
			scan_setup_reg <= RST_SETUP;
			phase_offset_reg <= RST_PHASE_OFFSET;
			level_offset_reg <= RST_LEVEL_OFFSET;
			bit_slot_reg <= RST_BIT_SLOT;
			tally_clear_reg <= RST_TALLY_CLEAR;
		end else if (wr_pend_reg) begin
			if (wr_idx_reg == IDX_RUN_CONTROL) begin
				run_control_reg <= hwdata[7:0];
			end else if (wr_idx_reg == IDX_SETUP) begin
				scan_setup_reg <= hwdata[7:0];
			end else if (wr_idx_reg == IDX_PHASE_OFFSET) begin
				phase_offset_reg <= hwdata[7:0];
			end else if (wr_idx_reg == IDX_LEVEL_OFFSET) begin
				level_offset_reg <= hwdata[7:0];
			end else if (wr_idx_reg == IDX_BIT_SLOT) begin
				bit_slot_reg <= hwdata[7:0];
			end else if (wr_idx_reg == IDX_TALLY_CLEAR) begin
				tally_clear_reg <= hwdata[7:0];
			end
		end
	end

	// read decode; unmapped words read zero
	always_comb begin
		logic [IDX_W-1:0] idx;
		idx = word_index(haddr);
		rd_value = 32'h0000_0000;
		if (idx == IDX_RUN_CONTROL) begin
			rd_value = {24'h000000, run_control_reg};
		end else if (idx == IDX_SETUP) begin
			rd_value = {24'h000000, scan_setup_reg};
		end else if (idx == IDX_PHASE_OFFSET) begin
			rd_value = {24'h000000, phase_offset_reg};
		end else if (idx == IDX_LEVEL_OFFSET) begin
			rd_value = {24'h000000, level_offset_reg};
		end else if (idx == IDX_BIT_SLOT) begin
			rd_value = {24'h000000, bit_slot_reg};
		end else if (idx == IDX_TALLY_CLEAR) begin
			rd_value = {24'h000000, tally_clear_reg};
		end else if (idx == IDX_FINISHED) begin
			rd_value = {16'h0000, finished_reg};
		end else if (idx >= IDX_LEVEL_BASE && idx < IDX_LEVEL_BASE + 10'(LANE_COUNT)) begin
			rd_value = {26'h0000000, level_reg[4'(idx - IDX_LEVEL_BASE)]};
		end else if (idx >= IDX_TALLY_BASE && idx < IDX_TALLY_BASE + 10'(LANE_COUNT)) begin
			rd_value = {16'h0000, tally_reg[4'(idx - IDX_TALLY_BASE)]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			hrdata <= rd_value;
		end
	end

	// scan_go edges drive start and abort
	assign scan_start = run_control_reg[GO_BIT] && !go_prev_reg;
	assign scan_abort = !run_control_reg[GO_BIT] && go_prev_reg;
	assign tally_wipe = !tally_clear_reg[CLEAR_BIT] && clear_prev_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_prev_reg <= 1'b0;
			clear_prev_reg <= 1'b0;
		end else begin
			go_prev_reg <= run_control_reg[GO_BIT];
			clear_prev_reg <= tally_clear_reg[CLEAR_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: if (scan_start) state_reg <= ST_RUN;
				ST_RUN: if (scan_abort) state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		case (scan_setup_reg[LEN_LSB +: 2])
			2'h0: length_target = LEN_SEL0;
			2'h1: length_target = LEN_SEL1;
			2'h2: length_target = LEN_SEL2;
			default: length_target = LEN_SEL3;
		endcase
	end

	assign slot_hit = rx_bit_valid && (rx_bit_pos == bit_slot_reg[SLOT_W-1:0]);

	// sampler steering outputs
	assign scan_phase_out = phase_offset_reg[PHASE_W-1:0];
	assign scan_sampler_en = (state_reg == ST_RUN) && (|busy_reg);

	genvar g;
	generate
		for (g = 0; g < LANE_COUNT; g++) begin : lane
			logic take;
			logic last;
			logic mismatch;
			// only qualifying samples advance the length count
			assign take = busy_reg[g] && slot_hit && mode_takes(mode, rx_data_bit[g]);
			assign last = (samples_reg[g] + 16'h0001) == length_target;
			assign mismatch = rx_scan_bit[g] ^ rx_data_bit[g];

			// automatic modes drive the search value, others the programmed offset
			assign scan_level_out[g*LEVEL_W +: LEVEL_W] = mode_is_level(mode) ? level_reg[g] :
				level_offset_reg[LEVEL_W-1:0];

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					busy_reg[g] <= 1'b0;
					finished_reg[g] <= 1'b0;
					samples_reg[g] <= '0;
				end else if (scan_abort) begin
					busy_reg[g] <= 1'b0;
					finished_reg[g] <= 1'b0;
				end else if (scan_start) begin
					// reserved and disabled codes never go busy
					busy_reg[g] <= mode_takes(mode, 1'b0) || mode_takes(mode, 1'b1);
					finished_reg[g] <= 1'b0;
					samples_reg[g] <= '0;
				end else if (take) begin
					samples_reg[g] <= samples_reg[g] + 16'h0001;
					if (last) begin
						busy_reg[g] <= 1'b0;
						finished_reg[g] <= 1'b1;
					end
				end
			end

			// tally saturates rather than wrapping, so a long scan never reads small
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					tally_reg[g] <= '0;
				end else if (tally_wipe) begin
					tally_reg[g] <= '0;
				end else if (take && tally_reg[g] != 16'hffff) begin
					case (mode)
						MODE_CMP_ALL, MODE_CMP_ZERO, MODE_CMP_ONE: begin
							if (mismatch) tally_reg[g] <= tally_reg[g] + 16'h0001;
						end
						MODE_CNT_ONES: begin
							if (rx_scan_bit[g]) tally_reg[g] <= tally_reg[g] + 16'h0001;
						end
						default: tally_reg[g] <= tally_reg[g];
					endcase
				end
			end

			// threshold search: scan bit high means the sample sat above the threshold
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					level_reg[g] <= LEVEL_START;
				end else if (scan_start && mode_is_level(mode)) begin
					level_reg[g] <= LEVEL_START;
				end else if (take) begin
					case (mode)
						MODE_AVG_ZERO, MODE_AVG_ONE: begin
							if (rx_scan_bit[g] && level_reg[g] != LEVEL_MAX) begin
								level_reg[g] <= level_reg[g] + 6'h01;
							end else if (!rx_scan_bit[g] && level_reg[g] != LEVEL_MIN) begin
								level_reg[g] <= level_reg[g] - 6'h01;
							end
						end
						MODE_LOW_ZERO, MODE_LOW_ONE: begin
							if (!rx_scan_bit[g] && level_reg[g] != LEVEL_MIN) begin
								level_reg[g] <= level_reg[g] - 6'h01;
							end
						end
						MODE_HIGH_ZERO, MODE_HIGH_ONE: begin
							if (rx_scan_bit[g] && level_reg[g] != LEVEL_MAX) begin
								level_reg[g] <= level_reg[g] + 6'h01;
							end
						end
						default: level_reg[g] <= level_reg[g];
					endcase
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// [ses_eye_scan_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ses_chk
	import ses_pkg::*;
(
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// scan sampler
	input wire logic scan_sampler_en,
	input wire logic [PHASE_W-1:0] scan_phase_out,
	input wire logic [LANE_COUNT*LEVEL_W-1:0] scan_level_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_ph, rd_ph, go_t;
	logic [IDX_W-1:0] ix;
	logic [7:0] mode_t, lvl_t;
	wire logic req = hsel && htrans[1] && hreadyout;
	wire logic off_m = mode_t[3:0] inside {4'h0, 4'h5, 4'h6, 4'h7, 4'hb, 4'hf};
	wire logic auto_m = mode_t[3] && !off_m;
	wire logic tally_ix = ix[9:4] == 6'h21;
	// shadows follow completed writes only, so a stalled data phase is skipped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'b0;
			rd_ph <= 1'b0;
			ix <= '0;
			go_t <= 1'b0;
			mode_t <= 8'h00;
			lvl_t <= 8'h00;
		end else if (hreadyout) begin
			wr_ph <= req && hwrite;
			rd_ph <= req && !hwrite;
			ix <= haddr[11:2];
			if (wr_ph && ix == IDX_RUN_CONTROL) go_t <= hwdata[0];
			if (wr_ph && ix == IDX_SETUP) mode_t <= {4'h0, hwdata[3:0]};
			if (wr_ph && ix == IDX_LEVEL_OFFSET) lvl_t <= hwdata[7:0];
		end
	end
	AST_OKAY: assert property (hresp == 1'b0) else $error("bad resp");
	AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout) else $error("long wait");
	AST_WAIT_WHY: assert property (!hreadyout |-> wr_ph && hsel && htrans[1] && !hwrite)
		else $error("stray wait");
	// finished and tally words carry sixteen bits, every other word eight or fewer
	AST_UPPER: assert property (rd_ph && hreadyout && !tally_ix && ix != IDX_FINISHED
		|-> hrdata[31:8] == 24'h0) else $error("upper bits");
	AST_PHASE: assert property (wr_ph && hreadyout && ix == IDX_PHASE_OFFSET
		|=> scan_phase_out == $past(hwdata[6:0])) else $error("phase");
	AST_LEVEL: assert property (!auto_m && !wr_ph
		|-> scan_level_out == {LANE_COUNT{lvl_t[5:0]}}) else $error("level");
	AST_OFF: assert property (off_m && !wr_ph |-> !scan_sampler_en)
		else $error("off");
	AST_IDLE: assert property (!go_t && $past(go_t, 3) == 1'b0 |-> !scan_sampler_en)
		else $error("abort");
	AST_START: assert property ($rose(go_t) && !off_m
		|-> ##[0:3] scan_sampler_en) else $error("start");
	COV_START: cover property ($rose(go_t) ##[1:5] scan_sampler_en);
	COV_WAIT: cover property (!hreadyout);
	COV_DONE: cover property (go_t && $fell(scan_sampler_en));
endmodule
bind ses_eye_scan ses_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hrdata, .hreadyout, .hresp, .scan_sampler_en, .scan_phase_out, .scan_level_out);
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb;
	import ses_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_bit_valid = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, e, seed = 32'h4bd30bfc;
	logic [1:0] htrans = 2'b00;
	logic [SLOT_W-1:0] rx_bit_pos = 5'h00;
	logic [LANE_COUNT-1:0] rx_data_bit = 16'h0000, rx_scan_bit = 16'h0000;
	logic hreadyout, hresp, scan_sampler_en, rd_dp = 1'b0;
	logic [PHASE_W-1:0] scan_phase_out;
	logic [LANE_COUNT*LEVEL_W-1:0] scan_level_out;
	logic [31:0] expq[$];
	int n_fail = 0, n_tests = 0, i;
	int cnt[LANE_COUNT], tal[LANE_COUNT], lev[LANE_COUNT];
	always #10 hclk = ~hclk;
	ses_eye_scan DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hreadyin(hreadyout), .hrdata, .hreadyout, .hresp, .rx_bit_valid, .rx_bit_pos,
		.rx_data_bit, .rx_scan_bit, .scan_sampler_en, .scan_phase_out, .scan_level_out);
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// hready is read a little after the edge, once the launch updates have landed
	task wait_rdy();
		for (int k = 0; k < 50; k++) begin
			#1;
			if (hreadyout === 1'b1) begin
				@(posedge hclk);
				return;
			end
			@(posedge hclk);
		end
		n_fail++;
		print_verdict();
	endtask
	task addr(logic w, logic [IDX_W-1:0] ix);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h0, ix, 2'b00};
	endtask
	task rd_data(logic [31:0] x);
		htrans <= 2'b00;
		hsel <= 1'b0;
		rd_dp <= 1'b1;
		expq.push_back(x);
		wait_rdy();
		rd_dp <= 1'b0;
	endtask
	task wr(logic [IDX_W-1:0] ix, logic [7:0] d);
		addr(1'b1, ix);
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		wait_rdy();
	endtask
	task rd(logic [IDX_W-1:0] ix, logic [31:0] x);
		addr(1'b0, ix);
		wait_rdy();
		rd_data(x);
	endtask
	// read address phase overlaps the write data phase to provoke the wait state
	task wr_rd(logic [IDX_W-1:0] ix, logic [7:0] d);
		addr(1'b1, ix);
		wait_rdy();
		hwdata <= {24'h0, d};
		addr(1'b0, ix);
		wait_rdy();
		rd_data({24'h0, d});
	endtask
	always @(negedge hclk) begin
		if (rd_dp && hreadyout) begin
			e = expq.pop_front();
			`CHK(hrdata, e)
		end
	end
	task run(logic [3:0] m, logic [1:0] sel, int slot, int maxk);
		int len, n, k;
		logic [31:0] r, sb, fin;
		logic [4:0] p;
		logic v, act, q, d, s;
		len = sel == 2'd0 ? int'(LEN_SEL0) : sel == 2'd1 ? int'(LEN_SEL1) :
			sel == 2'd2 ? int'(LEN_SEL2) : int'(LEN_SEL3);
		act = !(m inside {4'h0, 4'h5, 4'h6, 4'h7, 4'hb, 4'hf});
		wr(IDX_TALLY_CLEAR, 8'h01);
		wr(IDX_TALLY_CLEAR, 8'h00);
		wr(IDX_SETUP, {2'b00, sel, m});
		wr(IDX_BIT_SLOT, 8'(slot));
		wr(IDX_RUN_CONTROL, 8'h01);
		for (n = 0; n < LANE_COUNT; n++) begin
			tal[n] = 0;
			cnt[n] = 0;
			if (act && m[3]) lev[n] = 0;
		end
		repeat (3) @(posedge hclk);
		for (k = 0; k < maxk; k++) begin
			r = rnd();
			sb = rnd();
			v = r[20] | r[21];
			p = r[22] ? 5'(slot) : 5'(r[27:23] % 5'd20);
			rx_bit_valid <= v;
			rx_bit_pos <= p;
			rx_data_bit <= r[15:0];
			rx_scan_bit <= sb[15:0];
			for (n = 0; n < LANE_COUNT; n++) begin
				d = r[n];
				s = sb[n];
				q = m == 1 || m == 4 || (!d && (m == 2 || m[3:2] == 2'b10))
					|| (d && (m == 3 || m[3:2] == 2'b11));
				if (v && p == 5'(slot) && act && q && cnt[n] < len) begin
					cnt[n]++;
					if (m < 4) tal[n] += int'(d != s);
					if (m == 4) tal[n] += int'(s);
					if (s && m inside {8, 10, 12, 13} && lev[n] < 31) lev[n]++;
					if (!s && m inside {8, 9, 12, 14} && lev[n] > -32) lev[n]--;
				end
			end
			@(posedge hclk);
		end
		rx_bit_valid <= 1'b0;
		repeat (2) @(posedge hclk);
		for (n = 0; n < LANE_COUNT; n++) fin[n] = cnt[n] >= len;
		rd(IDX_FINISHED, {16'h0, fin[15:0]});
		for (n = 0; n < LANE_COUNT; n++) begin
			rd(IDX_W'(IDX_TALLY_BASE + n), 32'(tal[n]));
			rd(IDX_W'(IDX_LEVEL_BASE + n), 32'(lev[n]) & 32'h3f);
		end
		wr(IDX_RUN_CONTROL, 8'h00);
		// finished drops only after the falling scan_go edge has been seen
		repeat (2) @(posedge hclk);
		rd(IDX_FINISHED, 32'h0);
	endtask
	initial begin
		for (i = 0; i < LANE_COUNT; i++) lev[i] = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 8; i++) rd(IDX_W'(IDX_RUN_CONTROL + i), 32'h0);
		for (i = 0; i < 5; i++) wr_rd(IDX_W'(IDX_RUN_CONTROL + i), 8'(rnd()) & 8'hfe);
		for (i = 0; i < 16; i++) run(4'(i), 2'd0, (i * 7) % 20, 3000);
		run(4'h1, 2'd1, 19, 200);
		run(4'h1, 2'd1, 19, 6000);
		run(4'h4, 2'd2, 0, 24000);
		// longest length: must not finish within a few hundred samples
		run(4'h1, 2'd3, 5, 1000);
		print_verdict();
	end
endmodule
`default_nettype wire
